// ### src/rag_core.v
// Purpose: Register set and operand address generator of a 16-bit core.
// Assumes: One clock, synchronous active-high reset, sequencer on the same clock.
// Notes on behaviour
// (RL1) Addresses leave on a 24-bit path; data moves over a 16-bit path.
// (RL2) Seventeen 32-bit general registers, 32-bit instruction pointer, 16-bit status word.
// (RL3) Data registers accept byte, word and long word operations.
// (RL4) Address registers and stack pointer work on word and long word only.
// (RL5) Any of sixteen registers, 0..14 or the active stack pointer, may serve as index.
// (RL6) Status word holds a three-bit interrupt mask and five condition flags.
// (RL7) Status word holds a trace bit and a supervisor bit.
// (RL8) Datapath handles bits, decimal digits, bytes, words and long words.
// (RL9) Fourteen addressing modes in six categories are generated.
// (RL10) Post-increment uses then steps; pre-decrement steps then uses.
// (RL11) Indirect adds 16-bit displacement; indexed adds index and 8-bit displacement.
// (RL12) Relative modes use instruction pointer plus displacement, or index and 8-bit.
// (RL13) Absolute short uses one extension word; absolute long uses two.
// (RL14) Implied mode names status word, user stack, active stack or instruction pointer.
// (RL15) Step is one for byte, two for word, four for long word.
// (RL16) Byte step through the stack pointer is two.
// (RL17) Immediate data come from extension words; quick data from the operation word.
// (RL18) Register direct modes yield the register itself, no memory address.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "rag_map.vh"
module rag_core (
  input wire sys_clk_i,
  input wire rst_i,
  // Operand request from the sequencer.
  input wire start_i,
  input wire [3:0] mode_i,
  input wire [1:0] size_i,
  input wire [2:0] addr_reg_sel_i,
  input wire [4:0] index_reg_sel_i,
  input wire index_long_i,
  input wire [7:0] disp8_i,
  input wire [7:0] quick_i,
  input wire [1:0] implied_sel_i,
  // Extension words arrive over the 16-bit data path.
  input wire ext_valid_i,
  input wire [15:0] ext_word_i,
  // Register write port.
  input wire wr_en_i,
  input wire [4:0] wr_sel_i,
  input wire [1:0] wr_size_i,
  input wire [31:0] wr_data_i,
  // Status word and instruction pointer updates.
  input wire sw_wr_i,
  input wire [15:0] sw_data_i,
  input wire ip_wr_i,
  input wire [31:0] ip_data_i,
  input wire ip_adv_i,
  // Register read port.
  input wire [4:0] rd_sel_i,
  output reg [31:0] rd_data_o,
  // Results.
  output reg done_o,
  output reg ext_need_o,
  output reg is_mem_o,
  output reg [23:0] operand_location_o,
  output reg [31:0] operand_value_o,
  output reg [31:0] index_value_o,
  output wire [15:0] status_word_o,
  output wire [31:0] instruction_pointer_o,
  output wire supervisor_o,
  output wire trace_o,
  output wire [2:0] int_mask_o,
  output wire [4:0] cond_flags_o,
  output wire [3:0] bcd_low_o
);
  // Register file: 0..7 data, 8..14 address, 15 supervisor stack, 16 user stack.
  reg [31:0] gp_reg [0:16]; // RL2
  reg [31:0] ip_reg;
  reg [15:0] sw_reg;
  reg [1:0] state_reg;
  reg [3:0] mode_reg;
  reg [1:0] size_reg;
  reg [2:0] an_reg;
  reg [31:0] acc_reg;
  reg [15:0] hi_word_reg;
  wire super_w;
  wire [4:0] sp_phys_w;
  wire [4:0] an_phys_w;
  wire [31:0] an_val_w;
  wire [31:0] step_w;
  wire [31:0] index_raw_w;
  wire [31:0] index_val_w;
  wire [31:0] disp8_w;
  wire [4:0] wr_phys_w;
  wire [31:0] merged_w;
  wire [31:0] idx_sum_w;
  reg [31:0] implied_w;
  integer k;

  assign super_w = sw_reg[`RAG_SW_SUPER];
  // The active stack pointer follows the supervisor bit.
  assign sp_phys_w = super_w ? 5'h0F : 5'h10;
  assign an_phys_w = (addr_reg_sel_i == 3'h7) ? sp_phys_w : {2'h1, addr_reg_sel_i};
  assign an_val_w = gp_reg[an_phys_w];
  // Selector 15 means the active stack pointer, so index and writes map it.
  assign index_raw_w = (index_reg_sel_i == `RAG_SEL_SP) ? gp_reg[sp_phys_w] :
                       (index_reg_sel_i <= 5'h0E) ? gp_reg[index_reg_sel_i] : 32'h00000000; // RL5
  assign index_val_w = index_long_i ? index_raw_w : {{16{index_raw_w[15]}}, index_raw_w[15:0]};
  assign disp8_w = {{24{disp8_i[7]}}, disp8_i};
  assign idx_sum_w = index_val_w + disp8_w; // RL11
  assign wr_phys_w = (wr_sel_i == `RAG_SEL_SP) ? sp_phys_w :
                     (wr_sel_i == `RAG_SEL_USER_SP) ? 5'h10 : wr_sel_i;

  rag_step u_step (
    .size_i(size_i),
    .is_sp_i(addr_reg_sel_i == 3'h7),
    .step_o(step_w)
  );

  rag_sizer u_sizer (
    .old_i(gp_reg[wr_phys_w]),
    .new_i(wr_data_i),
    .size_i(wr_size_i),
    .is_addr_i(wr_phys_w >= 5'h08),
    .merged_o(merged_w)
  );

  // Implied references bypass any operand field.
  always @*
  begin
    implied_w = ip_reg;
    if (implied_sel_i == 2'h0)
      implied_w = {16'h0000, sw_reg}; // RL14
    else if (implied_sel_i == 2'h1)
      implied_w = gp_reg[16];
    else if (implied_sel_i == 2'h2)
      implied_w = gp_reg[sp_phys_w];
  end

  // Status outputs; reserved status bits always read zero.
  assign status_word_o = sw_reg;
  assign instruction_pointer_o = ip_reg;
  assign supervisor_o = sw_reg[`RAG_SW_SUPER]; // RL7
  assign trace_o = sw_reg[`RAG_SW_TRACE]; // RL7
  assign int_mask_o = sw_reg[`RAG_SW_MASK_HI:`RAG_SW_MASK_LO]; // RL6
  assign cond_flags_o = sw_reg[`RAG_SW_X:`RAG_SW_C]; // RL6
  // Packed decimal digit view of the index register's low nibble.
  assign bcd_low_o = index_raw_w[3:0]; // RL8

  // Register read port, registered one cycle later.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      rd_data_o <= 32'h00000000;
    else if (rd_sel_i == `RAG_SEL_SW)
      rd_data_o <= {16'h0000, sw_reg};
    else if (rd_sel_i == `RAG_SEL_IP)
      rd_data_o <= ip_reg;
    else if (rd_sel_i == `RAG_SEL_USER_SP)
      rd_data_o <= gp_reg[16];
    else if (rd_sel_i == `RAG_SEL_SP)
      rd_data_o <= gp_reg[sp_phys_w];
    else if (rd_sel_i < 5'h0F)
      rd_data_o <= gp_reg[rd_sel_i];
    else
      rd_data_o <= 32'h00000000;
  end

  // Status word and instruction pointer.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sw_reg <= `RAG_SW_RESET;
      ip_reg <= 32'h00000000;
    end
    else
    begin
      if (sw_wr_i)
        sw_reg <= sw_data_i & `RAG_SW_IMPL; // RL6
      if (ip_wr_i)
        ip_reg <= ip_data_i;
      else if (ip_adv_i)
        ip_reg <= ip_reg + `RAG_STEP_WORD;
    end
  end

  // Address generator and register file. A step from a pre/post mode wins
  // over a sequencer write in the same cycle only for that address register.
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (k = 0; k < 17; k = k + 1)
        gp_reg[k] <= 32'h00000000;
      state_reg <= `RAG_ST_IDLE;
      mode_reg <= `RAG_M_DREG;
      size_reg <= `RAG_SZ_BYTE;
      an_reg <= 3'h0;
      acc_reg <= 32'h00000000;
      hi_word_reg <= 16'h0000;
      done_o <= 1'b0;
      ext_need_o <= 1'b0;
      is_mem_o <= 1'b0;
      operand_location_o <= 24'h000000;
      operand_value_o <= 32'h00000000;
      index_value_o <= 32'h00000000;
    end
    else
    begin
      done_o <= 1'b0;
      if (wr_en_i && wr_sel_i <= `RAG_SEL_USER_SP && wr_sel_i != `RAG_SEL_IP)
        gp_reg[wr_phys_w] <= merged_w; // RL3
      case (state_reg)
        `RAG_ST_IDLE:
        begin
          if (start_i)
          begin
            mode_reg <= mode_i;
            size_reg <= size_i;
            an_reg <= addr_reg_sel_i;
            index_value_o <= index_val_w;
            is_mem_o <= 1'b1;
            state_reg <= `RAG_ST_DONE;
            case (mode_i) // RL9
              `RAG_M_DREG:
              begin
                is_mem_o <= 1'b0; // RL18
                operand_value_o <= gp_reg[{2'h0, addr_reg_sel_i}];
              end
              `RAG_M_AREG:
              begin
                is_mem_o <= 1'b0; // RL18
                operand_value_o <= an_val_w;
              end
              `RAG_M_IND: acc_reg <= an_val_w;
              `RAG_M_POST:
              begin
                acc_reg <= an_val_w; // RL10
                gp_reg[an_phys_w] <= an_val_w + step_w; // RL10
              end
              `RAG_M_PRE:
              begin
                acc_reg <= an_val_w - step_w; // RL10
                gp_reg[an_phys_w] <= an_val_w - step_w; // RL10
              end
              `RAG_M_DISP, `RAG_M_ABSW, `RAG_M_PCD:
              begin
                acc_reg <= (mode_i == `RAG_M_DISP) ? an_val_w : ip_reg;
                ext_need_o <= 1'b1;
                state_reg <= `RAG_ST_EXT1;
              end
              `RAG_M_IDX: acc_reg <= an_val_w + idx_sum_w; // RL11
              `RAG_M_PCX: acc_reg <= ip_reg + idx_sum_w; // RL12
              `RAG_M_ABSL, `RAG_M_IMM:
              begin
                is_mem_o <= (mode_i == `RAG_M_ABSL);
                ext_need_o <= 1'b1;
                state_reg <= (mode_i == `RAG_M_IMM && size_i != `RAG_SZ_LONG) ? `RAG_ST_EXT1 : `RAG_ST_EXT2;
              end
              `RAG_M_QUICK:
              begin
                is_mem_o <= 1'b0;
                operand_value_o <= {{24{quick_i[7]}}, quick_i}; // RL17
              end
              default:
              begin
                is_mem_o <= 1'b0;
                operand_value_o <= implied_w; // RL14
              end
            endcase
          end
        end
        `RAG_ST_EXT2:
        begin
          // First of two extension words is the high half.
          if (ext_valid_i)
          begin
            hi_word_reg <= ext_word_i; // RL13
            state_reg <= `RAG_ST_EXT1;
          end
        end
        `RAG_ST_EXT1:
        begin
          if (ext_valid_i)
          begin
            ext_need_o <= 1'b0;
            state_reg <= `RAG_ST_DONE;
            if (mode_reg == `RAG_M_ABSW)
              acc_reg <= {{16{ext_word_i[15]}}, ext_word_i}; // RL13
            else if (mode_reg == `RAG_M_ABSL)
              acc_reg <= {hi_word_reg, ext_word_i}; // RL13
            else if (mode_reg == `RAG_M_IMM)
              operand_value_o <= (size_reg == `RAG_SZ_LONG) ? {hi_word_reg, ext_word_i} :
                                 {16'h0000, ext_word_i}; // RL17
            else
              acc_reg <= acc_reg + {{16{ext_word_i[15]}}, ext_word_i}; // RL11 RL12
          end
        end
        default:
        begin
          // Only the low 24 bits reach the address path.
          operand_location_o <= acc_reg[23:0]; // RL1
          done_o <= 1'b1;
          state_reg <= `RAG_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### src/rag_map.vh
// Purpose: Constants for the register set and operand address generator.
// Assumes: Included by bare name from the rag design files.
// Notes: Mode codes are local to this block; the mode port carries them.
`ifndef RAG_MAP_VH
`define RAG_MAP_VH
// Widths.
`define RAG_ADDR_W 24
`define RAG_DATA_W 16
`define RAG_REG_W 32
`define RAG_SW_W 16
// Register selector: 0..7 data, 8..14 address, 15 active stack pointer, 16 instruction pointer.
`define RAG_SEL_SP 5'h0F
`define RAG_SEL_IP 5'h10
`define RAG_SEL_USER_SP 5'h11
`define RAG_SEL_SW 5'h12
// Operand sizes.
`define RAG_SZ_BYTE 2'h0
`define RAG_SZ_WORD 2'h1
`define RAG_SZ_LONG 2'h2
// Size steps.
`define RAG_STEP_BYTE 32'h00000001
`define RAG_STEP_WORD 32'h00000002
`define RAG_STEP_LONG 32'h00000004
// Status word field positions.
`define RAG_SW_TRACE 15
`define RAG_SW_SUPER 13
`define RAG_SW_MASK_HI 10
`define RAG_SW_MASK_LO 8
`define RAG_SW_X 4
`define RAG_SW_N 3
`define RAG_SW_Z 2
`define RAG_SW_V 1
`define RAG_SW_C 0
`define RAG_SW_IMPL 16'hA71F
`define RAG_SW_RESET 16'h2700
// Addressing modes, fourteen in all.
`define RAG_M_DREG 4'h0
`define RAG_M_AREG 4'h1
`define RAG_M_IND 4'h2
`define RAG_M_POST 4'h3
`define RAG_M_PRE 4'h4
`define RAG_M_DISP 4'h5
`define RAG_M_IDX 4'h6
`define RAG_M_ABSW 4'h7
`define RAG_M_ABSL 4'h8
`define RAG_M_PCD 4'h9
`define RAG_M_PCX 4'hA
`define RAG_M_IMM 4'hB
`define RAG_M_QUICK 4'hC
`define RAG_M_IMPL 4'hD
// Address generator states.
`define RAG_ST_IDLE 2'h0
`define RAG_ST_EXT1 2'h1
`define RAG_ST_EXT2 2'h2
`define RAG_ST_DONE 2'h3
`endif

// ### src/rag_step.v
// Purpose: Size step for post-increment and pre-decrement.
// Assumes: Size code from rag_map.vh.
// Notes: Byte access through the stack pointer steps by two.
`timescale 1ns/10ps
`default_nettype none
`include "rag_map.vh"
module rag_step (
  input wire [1:0] size_i,
  input wire is_sp_i,
  output reg [31:0] step_o
);
  // Keeps the stack pointer word aligned on byte pushes.
  always @*
  begin
    step_o = `RAG_STEP_LONG;
    if (size_i == `RAG_SZ_BYTE)
    begin
      step_o = is_sp_i ? `RAG_STEP_WORD : `RAG_STEP_BYTE; // RL16
    end
    else if (size_i == `RAG_SZ_WORD)
    begin
      step_o = `RAG_STEP_WORD; // RL15
    end
  end
endmodule
`default_nettype wire

// ### src/rag_sizer.v
// Purpose: Merges a sized write into a 32-bit register.
// Assumes: Address registers never see a byte write.
// Notes: Address register word writes sign extend, data byte and word writes keep upper bits.
`timescale 1ns/10ps
`default_nettype none
`include "rag_map.vh"
module rag_sizer (
  input wire [31:0] old_i,
  input wire [31:0] new_i,
  input wire [1:0] size_i,
  input wire is_addr_i,
  output reg [31:0] merged_o
);
  // Byte and word writes to data registers leave the upper part alone.
  always @*
  begin
    merged_o = new_i;
    if (is_addr_i)
    begin
      if (size_i != `RAG_SZ_LONG)
        merged_o = {{16{new_i[15]}}, new_i[15:0]}; // RL4
    end
    else if (size_i == `RAG_SZ_BYTE)
    begin
      merged_o = {old_i[31:8], new_i[7:0]}; // RL3
    end
    else if (size_i == `RAG_SZ_WORD)
    begin
      merged_o = {old_i[31:16], new_i[15:0]}; // RL3
    end
  end
endmodule
`default_nettype wire

// ### verification/rag_core_asserts.sv
// Purpose: Port-level checks for the register set and address generator.
// Assumes: One clock, synchronous active-high reset.
// Notes: Acceptance of a start is rebuilt from done_o, since busy is not a port.
`timescale 1ns/10ps
`default_nettype none
`include "rag_map.vh"
module rag_core_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] mode_i,
  input wire logic sw_wr_i,
  input wire logic [15:0] sw_data_i,
  input wire logic [4:0] rd_sel_i,
  input wire logic [31:0] rd_data_o,
  input wire logic done_o,
  input wire logic ext_need_o,
  input wire logic is_mem_o,
  input wire logic [15:0] status_word_o,
  input wire logic supervisor_o,
  input wire logic trace_o,
  input wire logic [2:0] int_mask_o,
  input wire logic [4:0] cond_flags_o
);
  logic idle_reg;
  logic [3:0] mode_reg;
  wire logic accept = start_i && (idle_reg || done_o);
  // A start in the done cycle is taken too, so idle must count that cycle as free.
  always @(posedge sys_clk_i)
  begin
    idle_reg <= rst_i ? 1'b1 : (accept ? 1'b0 : (done_o ? 1'b1 : idle_reg));
    mode_reg <= rst_i ? 4'h0 : (accept ? mode_i : mode_reg);
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_status: assert property ($fell(rst_i) |-> status_word_o == `RAG_SW_RESET)
    else $error("status word not at reset value");
  a_sw_fields: assert property (supervisor_o == status_word_o[`RAG_SW_SUPER] && trace_o == status_word_o[15]
    && int_mask_o == status_word_o[10:8] && cond_flags_o == status_word_o[4:0]) else $error("status view wrong");
  a_sw_write: assert property (sw_wr_i |=> status_word_o == ($past(sw_data_i) & `RAG_SW_IMPL))
    else $error("status write not masked");
  a_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
  a_plain_done: assert property (accept && !(mode_i inside {`RAG_M_DISP, `RAG_M_ABSW, `RAG_M_ABSL,
    `RAG_M_PCD, `RAG_M_IMM}) |-> ##1 !done_o ##1 done_o) else $error("done latency wrong");
  a_long_ext: assert property (accept && mode_i == `RAG_M_ABSL |=> ext_need_o [*2])
    else $error("long absolute did not ask for two words");
  a_direct_nomem: assert property (done_o && mode_reg <= `RAG_M_AREG |-> !is_mem_o)
    else $error("register direct flagged as memory");
  a_status_read: assert property (rd_sel_i == `RAG_SEL_SW |=> rd_data_o[15:0] == $past(status_word_o))
    else $error("status read wrong");
endmodule
bind rag_core rag_core_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i),
  .sw_wr_i(sw_wr_i), .sw_data_i(sw_data_i), .rd_sel_i(rd_sel_i), .rd_data_o(rd_data_o), .done_o(done_o),
  .ext_need_o(ext_need_o), .is_mem_o(is_mem_o), .status_word_o(status_word_o), .supervisor_o(supervisor_o),
  .trace_o(trace_o), .int_mask_o(int_mask_o), .cond_flags_o(cond_flags_o));
`default_nettype wire

// ### verification/rag_core_tb.sv
// Purpose: Self-checking bench for the register set and address generator.
// Assumes: Constants from rag_map.vh; one 40 MHz clock.
// Notes: Random values come from a fixed seed, so runs repeat.
`timescale 1ns/10ps
`default_nettype none
`include "rag_map.vh"
module rag_core_tb;
  logic sys_clk_i = 0, rst_i = 1, start_i = 0, index_long_i = 0, ext_valid_i = 0, wr_en_i = 0;
  logic sw_wr_i = 0, ip_wr_i = 0, ip_adv_i = 0, done_o, ext_need_o, is_mem_o, supervisor_o, trace_o, il;
  logic [3:0] mode_i = 0, bcd_low_o, m;
  logic [1:0] size_i = 0, wr_size_i = 0, implied_sel_i = 0, z, isel;
  logic [2:0] addr_reg_sel_i = 0, int_mask_o, an;
  logic [4:0] index_reg_sel_i = 0, wr_sel_i = 0, rd_sel_i = 0, cond_flags_o, xs;
  logic [7:0] disp8_i = 0, quick_i = 0, d8, q;
  logic [15:0] ext_word_i = 0, sw_data_i = 0, status_word_o, sw;
  logic [31:0] wr_data_i = 0, ip_data_i = 0, rd_data_o, operand_value_o, index_value_o, instruction_pointer_o;
  logic [23:0] operand_location_o;
  logic [31:0] r [0:15];
  logic [31:0] d, a, x, w, e, ip, user_sp;
  int failures = 0, checks = 0, n, i, nw;
  rag_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i), .size_i(size_i),
    .addr_reg_sel_i(addr_reg_sel_i), .index_reg_sel_i(index_reg_sel_i), .index_long_i(index_long_i),
    .disp8_i(disp8_i), .quick_i(quick_i), .implied_sel_i(implied_sel_i), .ext_valid_i(ext_valid_i),
    .ext_word_i(ext_word_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i), .wr_size_i(wr_size_i), .wr_data_i(wr_data_i),
    .sw_wr_i(sw_wr_i), .sw_data_i(sw_data_i), .ip_wr_i(ip_wr_i), .ip_data_i(ip_data_i), .ip_adv_i(ip_adv_i),
    .rd_sel_i(rd_sel_i), .rd_data_o(rd_data_o), .done_o(done_o), .ext_need_o(ext_need_o), .is_mem_o(is_mem_o),
    .operand_location_o(operand_location_o), .operand_value_o(operand_value_o), .index_value_o(index_value_o),
    .status_word_o(status_word_o), .instruction_pointer_o(instruction_pointer_o), .supervisor_o(supervisor_o),
    .trace_o(trace_o), .int_mask_o(int_mask_o), .cond_flags_o(cond_flags_o), .bcd_low_o(bcd_low_o));
  // Free-running 25 ns clock.
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tk;
    @(posedge sys_clk_i);
  endtask
  // Byte writes to an address register never happen, so the merge only sign extends words there.
  function automatic logic [31:0] mrg(input logic [31:0] o, v, input logic [1:0] s, input logic ad);
    if (s == `RAG_SZ_LONG || ad)
      return s == `RAG_SZ_LONG ? v : {{16{v[15]}}, v[15:0]};
    return s == `RAG_SZ_WORD ? {o[31:16], v[15:0]} : {o[31:8], v[7:0]};
  endfunction
  function automatic logic [31:0] stp(input logic [1:0] s, input logic sp);
    return s == `RAG_SZ_LONG ? 32'h4 : (s == `RAG_SZ_WORD || sp) ? 32'h2 : 32'h1;
  endfunction
  task wreg(input logic [4:0] s, input logic [1:0] sz, input logic [31:0] v);
    wr_en_i <= 1;
    wr_sel_i <= s;
    wr_size_i <= sz;
    wr_data_i <= v;
    tk;
    wr_en_i <= 0;
    if (s < 16)
      r[s[3:0]] = mrg(r[s[3:0]], v, sz, s[3]);
    tk;
  endtask
  task rd(input logic [4:0] s);
    rd_sel_i <= s;
    tk;
    @(negedge sys_clk_i);
    d = rd_data_o;
    tk;
  endtask
  // Waits at falling edges so the flag has settled, with a bound against a hang.
  task hold(input logic fin);
    n = 0;
    @(negedge sys_clk_i);
    while ((fin ? done_o : ext_need_o) !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge sys_clk_i);
    end
    if (n == 20)
      chk(0, 1);
    tk;
  endtask
  task op(input logic [3:0] md, input logic [1:0] sz, input logic [2:0] ar, input int k, input logic [31:0] v);
    start_i <= 1;
    mode_i <= md;
    size_i <= sz;
    addr_reg_sel_i <= ar;
    tk;
    start_i <= 0;
    if (k > 0)
    begin
      hold(0);
      ext_valid_i <= 1;
      ext_word_i <= k > 1 ? v[31:16] : v[15:0];
      tk;
      ext_word_i <= v[15:0];
      if (k > 1)
        tk;
      ext_valid_i <= 0;
    end
    hold(1);
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The whole sequence needs under a thousand cycles; five thousand means a hang.
  initial
  begin
    #125000;
    failures++;
    conclude;
  end
  // Main sequence: reset view, register writes, status and pointer, then every mode.
  initial
  begin
    void'($urandom(7));
    repeat (12) tk;
    rst_i <= 0;
    chk(status_word_o, `RAG_SW_RESET);
    for (i = 0; i < 16; i++)
    begin
      wreg(i[4:0], `RAG_SZ_LONG, $urandom);
      rd(i[4:0]);
      chk(d, r[i]);
    end
    for (i = 0; i < 3; i++)
    begin
      wreg(i[1] ? 5'h09 : 5'h01, i[1] ? `RAG_SZ_WORD : i[1:0], $urandom | 32'h00008000);
      rd(i[1] ? 5'h09 : 5'h01);
      chk(d, r[i[1] ? 9 : 1]);
    end
    user_sp = $urandom;
    wreg(`RAG_SEL_USER_SP, `RAG_SZ_LONG, user_sp);
    sw = $urandom | 32'h00002000;
    sw_data_i <= sw;
    sw_wr_i <= 1;
    tk;
    sw_wr_i <= 0;
    sw = sw & `RAG_SW_IMPL;
    rd(`RAG_SEL_SW);
    chk(d[15:0], sw);
    chk({trace_o, supervisor_o, int_mask_o, cond_flags_o}, {sw[15], sw[13], sw[10:8], sw[4:0]});
    ip = $urandom & 32'hFFFFFFFE;
    ip_data_i <= ip;
    // Both strobes high in the first cycle: the load must win over the advance.
    ip_wr_i <= 1;
    ip_adv_i <= 1;
    tk;
    ip_wr_i <= 0;
    ip_adv_i <= 1;
    tk;
    ip_adv_i <= 0;
    ip = ip + 32'h2;
    rd(`RAG_SEL_IP);
    chk(d, ip);
    chk(instruction_pointer_o, ip);
    rd(`RAG_SEL_USER_SP);
    chk(d, user_sp);
    for (i = 0; i < 42; i++)
    begin
      m = i % 14;
      an = i % 8;
      z = m < 2 ? `RAG_SZ_LONG : an == 3'h7 ? `RAG_SZ_BYTE : $urandom_range(2);
      if (m == `RAG_M_IMM && z == `RAG_SZ_BYTE)
        z = `RAG_SZ_WORD;
      xs = $urandom_range(15);
      il = $urandom;
      d8 = $urandom;
      q = $urandom;
      isel = $urandom;
      w = $urandom;
      if (m == `RAG_M_ABSW)
        w[15] = 1'b0;
      a = r[{1'b1, an}];
      x = il ? r[xs] : {{16{r[xs][15]}}, r[xs][15:0]};
      index_reg_sel_i <= xs;
      index_long_i <= il;
      disp8_i <= d8;
      quick_i <= q;
      implied_sel_i <= isel;
      case (m)
        `RAG_M_DREG: e = r[an];
        `RAG_M_AREG, `RAG_M_IND, `RAG_M_POST: e = a;
        `RAG_M_PRE: e = a - stp(z, an == 3'h7);
        `RAG_M_DISP: e = a + {{16{w[15]}}, w[15:0]};
        `RAG_M_IDX: e = a + x + {{24{d8[7]}}, d8};
        `RAG_M_ABSW: e = w[15:0];
        `RAG_M_ABSL: e = w;
        `RAG_M_PCD: e = ip + {{16{w[15]}}, w[15:0]};
        `RAG_M_PCX: e = ip + x + {{24{d8[7]}}, d8};
        `RAG_M_IMM: e = z == `RAG_SZ_LONG ? w : w[15:0];
        `RAG_M_QUICK: e = {{24{q[7]}}, q};
        default: e = isel == 0 ? sw : isel == 1 ? user_sp : isel == 2 ? r[15] : ip;
      endcase
      nw = (m == `RAG_M_ABSL || (m == `RAG_M_IMM && z == `RAG_SZ_LONG)) ? 2 :
        (m inside {`RAG_M_DISP, `RAG_M_ABSW, `RAG_M_PCD, `RAG_M_IMM}) ? 1 : 0;
      op(m, z, an, nw, w);
      if (m == `RAG_M_POST || m == `RAG_M_PRE)
        r[{1'b1, an}] = m == `RAG_M_PRE ? e : a + stp(z, an == 3'h7);
      if (nw == 0)
        chk(n, 1);
      if (m inside {[`RAG_M_IND:`RAG_M_PCX]})
        chk(operand_location_o, e[23:0]);
      else
        chk(operand_value_o, e);
      if (m == `RAG_M_IDX || m == `RAG_M_PCX)
        chk(index_value_o, x);
      chk(is_mem_o, m >= `RAG_M_IND && m <= `RAG_M_PCX);
      chk(bcd_low_o, r[xs][3:0]);
    end
    for (i = 8; i < 16; i++)
    begin
      rd(i[4:0]);
      chk(d, r[i]);
    end
    conclude;
  end
endmodule
`default_nettype wire
